// ==== bmid_decode.sv ====
/*
 * Instruction decoder and execution timing for an 8-bit core, 16-bit words.
 * Assumes the fetch unit presents the next program word on FETCH_WORD with
 * FETCH_VALID, advancing one word per instruction cycle (FETCH_ADVANCE), and
 * the datapath reports conditional outcomes on COND_TRUE in the execute cycle.
 */
// Function
// (RL1) decode the 75 standard instructions plus eight extended ones
// (RL2) one word per instruction, four instructions take two words
// (RL3) split single word into opcode and operand fields
// (RL4) classify into byte, bit, literal or control groups
// (RL5) byte ops carry file register, destination and access selectors
// (RL6) destination zero writes working register, one writes file register
// (RL7) bit ops carry file register, bit number and access selector
// (RL8) literal ops take immediate, pointer selector or nothing
// (RL9) control ops take address, call mode, table mode or nothing
// (RL10) second word starts with four ones, alone executes as no-op
// (RL11) single word takes one cycle, two if taken or PC changes
// (RL12) double-word instructions take two cycles
// (RL13) instruction cycle is four oscillator periods
// (RL14) taken two-word branch takes three cycles
// (RL15) compare-and-skip takes one, or two/three when skipping
// (RL16) discarded fetched word becomes a no-op
`default_nettype none
`include "bmid_consts.svh"
module bmid_decode
   import bmid_pkg::*;
#(
   parameter int IW = `BMID_IW
) (
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic [IW-1:0] FETCH_WORD,
   input wire logic FETCH_VALID,
   input wire logic COND_TRUE,
   input wire logic EXT_ENABLE,
   output logic FETCH_ADVANCE,
   output logic CYCLE_EN,
   output logic [3:0] GROUP,
   output logic [7:0] OPCODE,
   output logic [7:0] FILE_SEL,
   output logic DEST_FILE,
   output logic WR_WORKING_REG,
   output logic WR_FILE_REG,
   output logic ACCESS_SEL,
   output logic [2:0] BIT_NUM,
   output logic [7:0] LITERAL,
   output logic [1:0] PTR_SEL,
   output logic [19:0] PROG_ADDR,
   output logic CALL_MODE,
   output logic [1:0] TABLE_MODE,
   output logic IS_EXTENDED,
   output logic TWO_WORD,
   output logic NOP_CYCLE,
   output logic INSTR_VALID
);
   // field slices below are fixed to the 16-bit word layout
   if (IW != 16) begin : g_iw_check
      $error("bmid_decode: instruction word must be 16 bits");
   end

   logic cyc;
   bmid_qdiv #(.PERIODS(`BMID_OSC_PER_CYCLE)) u_qdiv ( // RL13
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .cycle_en(cyc),
      .phase()
   );

   // combinational classification of the fetched word
   logic [15:0] w;
   logic dw_first;
   logic is_skip;
   logic is_branch;
   logic is_cbranch;
   logic is_ext;
   logic has_d;
   logic second_tag;
   bmid_group_t grp;

   always_comb begin
      w = FETCH_WORD;
      second_tag = (w[15:12] == `BMID_SECOND_WORD_TAG); // RL10
      // move, call, goto, pointer load; the extended move only when enabled
      dw_first = (w[15:12] == 4'hc) || (w[15:9] == 7'h76) || (w[15:8] == 8'hef)
         || (w[15:6] == 10'h3b8) || (EXT_ENABLE && w[15:8] == 8'heb); // RL2
      is_ext = EXT_ENABLE && ((w[15:8] == 8'he8) || (w[15:8] == 8'he9) || (w[15:8] == 8'hea)
         || (w[15:8] == 8'heb) || (w[15:0] == 16'h0014)); // RL1
      is_skip = (w[15:11] == 5'h0c) || (w[15:13] == 3'h1 && w[11:10] == 2'h3)
         || (w[15:11] == 5'h09) || (w[15:12] == 4'hb || w[15:12] == 4'ha); // RL15
      // conditional branches flush only when their test holds
      is_cbranch = (w[15:11] == 5'h1c); // RL11
      is_branch = (w[15:11] == 5'h1a) || (w[15:11] == 5'h1b) || (w[15:8] == 8'h0c)
         || (w[15:8] == 8'hec) || (w[15:8] == 8'hef) || (w[15:1] == 15'h0009)
         || (w[15:1] == 15'h0008) || (w[15:0] == 16'h00ff); // RL11
      has_d = (w[15:14] == 2'h0 && w[13:10] != 4'h0) || w[15:12] == 4'h4 || w[15:12] == 4'h5
         || (w[15:10] == 6'h00 && w[9] == 1'b0 && w[8:0] == 9'h0) ;
      if (w[15:12] >= 4'h7 && w[15:12] <= 4'hb) begin
         grp = BMID_GRP_BIT; // RL4
      end else if ((w[15:12] == 4'h0 && w[11:8] >= 4'h8) || w[15:6] == 10'h3b8) begin
         // pointer load sits in the control opcode space but is a literal op
         grp = BMID_GRP_LIT; // RL8
      end else if (w[15:12] == 4'he || w[15:12] == 4'hd || w[15:8] == 8'h00) begin
         grp = BMID_GRP_CTRL;
      end else begin
         grp = BMID_GRP_BYTE;
      end
   end

   bmid_state_t st_r;
   bmid_state_t st_nxt;
   logic [15:0] first_r;
   logic [15:0] first_nxt;
   logic branch_pending_r;
   logic branch_pending_nxt;
   logic skip_r;
   logic skip_nxt;
   logic [3:0] grp_nxt;
   logic [7:0] op_nxt;
   logic [7:0] f_nxt;
   logic d_nxt;
   logic wrw_nxt;
   logic wrf_nxt;
   logic a_nxt;
   logic [2:0] b_nxt;
   logic [7:0] k_nxt;
   logic [1:0] ptr_nxt;
   logic [19:0] n_nxt;
   logic s_nxt;
   logic [1:0] m_nxt;
   logic ext_nxt;
   logic tw_nxt;
   logic nop_nxt;
   logic val_nxt;
   logic [3:0] grp_r;
   logic [7:0] op_r;
   logic [7:0] f_r;
   logic d_r;
   logic wrw_r;
   logic wrf_r;
   logic a_r;
   logic [2:0] b_r;
   logic [7:0] k_r;
   logic [1:0] ptr_r;
   logic [19:0] n_r;
   logic s_r;
   logic [1:0] m_r;
   logic ext_r;
   logic tw_r;
   logic nop_r;
   logic val_r;

   always_comb begin
      st_nxt = st_r;
      first_nxt = first_r;
      branch_pending_nxt = branch_pending_r;
      skip_nxt = skip_r;
      grp_nxt = grp_r;
      op_nxt = op_r;
      f_nxt = f_r;
      d_nxt = d_r;
      wrw_nxt = wrw_r;
      wrf_nxt = wrf_r;
      a_nxt = a_r;
      b_nxt = b_r;
      k_nxt = k_r;
      ptr_nxt = ptr_r;
      n_nxt = n_r;
      s_nxt = s_r;
      m_nxt = m_r;
      ext_nxt = ext_r;
      tw_nxt = tw_r;
      nop_nxt = nop_r;
      val_nxt = val_r;
      if (cyc) begin
         nop_nxt = 1'b0;
         val_nxt = 1'b0;
         wrw_nxt = 1'b0;
         wrf_nxt = 1'b0;
         unique case (st_r)
            BMID_ST_EXEC: begin
               if (FETCH_VALID) begin
                  val_nxt = 1'b1;
                  grp_nxt = grp; // RL4
                  op_nxt = w[15:8]; // RL3
                  f_nxt = w[`BMID_F_MSB:`BMID_F_LSB]; // RL5
                  a_nxt = w[`BMID_A_BIT]; // RL7
                  d_nxt = w[`BMID_D_BIT];
                  b_nxt = w[`BMID_B_MSB:`BMID_B_LSB]; // RL7
                  k_nxt = w[7:0]; // RL8
                  ptr_nxt = w[5:4]; // RL8
                  s_nxt = w[0]; // RL9
                  m_nxt = w[1:0]; // RL9
                  n_nxt = {9'h0, w[10:0]}; // RL9
                  ext_nxt = is_ext;
                  tw_nxt = dw_first;
                  // lone second word falls through as a no-op
                  nop_nxt = second_tag; // RL10
                  wrw_nxt = !second_tag && grp == BMID_GRP_BYTE && has_d && !w[`BMID_D_BIT]; // RL6
                  wrf_nxt = !second_tag && grp == BMID_GRP_BYTE && has_d && w[`BMID_D_BIT]; // RL6
                  if (dw_first) begin
                     first_nxt = w;
                     branch_pending_nxt = (w[15:8] == 8'hef) || (w[15:9] == 7'h76); // RL14
                     st_nxt = BMID_ST_SECOND; // RL12
                  end else if (is_branch || ((is_skip || is_cbranch) && COND_TRUE)) begin
                     // remember a skip: only then may the dropped word be two long
                     skip_nxt = is_skip; // RL15
                     st_nxt = BMID_ST_FLUSH; // RL11
                  end
               end
            end
            BMID_ST_SECOND: begin
               val_nxt = FETCH_VALID;
               n_nxt = {first_r[7:0], FETCH_WORD[11:0]}; // RL2
               f_nxt = FETCH_WORD[7:0];
               k_nxt = FETCH_WORD[7:0];
               tw_nxt = 1'b1;
               st_nxt = branch_pending_r ? BMID_ST_FLUSH : BMID_ST_EXEC; // RL14
               branch_pending_nxt = 1'b0;
            end
            BMID_ST_FLUSH: begin
               // discard the prefetched word; a skipped two-word op costs one more
               nop_nxt = 1'b1; // RL16
               val_nxt = 1'b1;
               st_nxt = (skip_r && dw_first) ? BMID_ST_FLUSH2 : BMID_ST_EXEC; // RL15
               skip_nxt = 1'b0;
            end
            BMID_ST_FLUSH2: begin
               nop_nxt = 1'b1; // RL16
               val_nxt = 1'b1;
               st_nxt = BMID_ST_EXEC;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_r <= BMID_ST_EXEC;
         first_r <= 16'h0000;
         branch_pending_r <= 1'b0;
         skip_r <= 1'b0;
         grp_r <= 4'h0;
         op_r <= 8'h00;
         f_r <= 8'h00;
         d_r <= 1'b0;
         wrw_r <= 1'b0;
         wrf_r <= 1'b0;
         a_r <= 1'b0;
         b_r <= 3'h0;
         k_r <= 8'h00;
         ptr_r <= 2'h0;
         n_r <= 20'h00000;
         s_r <= 1'b0;
         m_r <= 2'h0;
         ext_r <= `BMID_EXT_ENABLE_RST;
         tw_r <= 1'b0;
         nop_r <= 1'b0;
         val_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         first_r <= first_nxt;
         branch_pending_r <= branch_pending_nxt;
         skip_r <= skip_nxt;
         grp_r <= grp_nxt;
         op_r <= op_nxt;
         f_r <= f_nxt;
         d_r <= d_nxt;
         wrw_r <= wrw_nxt;
         wrf_r <= wrf_nxt;
         a_r <= a_nxt;
         b_r <= b_nxt;
         k_r <= k_nxt;
         ptr_r <= ptr_nxt;
         n_r <= n_nxt;
         s_r <= s_nxt;
         m_r <= m_nxt;
         ext_r <= ext_nxt;
         tw_r <= tw_nxt;
         nop_r <= nop_nxt;
         val_r <= val_nxt;
      end
   end

   assign CYCLE_EN = cyc;
   assign FETCH_ADVANCE = cyc;
   assign GROUP = grp_r;
   assign OPCODE = op_r;
   assign FILE_SEL = f_r;
   assign DEST_FILE = d_r;
   // writes are suppressed while a discarded word passes
   assign WR_WORKING_REG = wrw_r && !nop_r; // RL16
   assign WR_FILE_REG = wrf_r && !nop_r; // RL16
   assign ACCESS_SEL = a_r;
   assign BIT_NUM = b_r;
   assign LITERAL = k_r;
   assign PTR_SEL = ptr_r;
   assign PROG_ADDR = n_r;
   assign CALL_MODE = s_r;
   assign TABLE_MODE = m_r;
   assign IS_EXTENDED = ext_r;
   assign TWO_WORD = tw_r;
   assign NOP_CYCLE = nop_r;
   assign INSTR_VALID = val_r;
endmodule // bmid_decode
`default_nettype wire

// ==== bmid_consts.svh ====
/*
 * Constants for the instruction decoder: field positions, opcode patterns, timing.
 * Assumes inclusion by bmid_qdiv.sv and bmid_decode.sv only.
 */
`ifndef BMID_CONSTS_SVH
`define BMID_CONSTS_SVH

`define BMID_IW 16
`define BMID_OSC_PER_CYCLE 4
`define BMID_CORE_PERIOD_NS 5
`define BMID_SECOND_WORD_TAG 4'hf
`define BMID_F_LSB 0
`define BMID_F_MSB 7
`define BMID_A_BIT 8
`define BMID_D_BIT 9
`define BMID_B_LSB 9
`define BMID_B_MSB 11
`define BMID_EXT_ENABLE_RST 1'b0

`endif

// ==== bmid_pkg.sv ====
/*
 * Types shared by the decoder modules.
 * Assumes it is compiled before every module that imports it.
 */
`default_nettype none
package bmid_pkg;
   typedef enum logic [3:0] {
      BMID_GRP_BYTE = 4'h1,
      BMID_GRP_BIT = 4'h2,
      BMID_GRP_LIT = 4'h4,
      BMID_GRP_CTRL = 4'h8
   } bmid_group_t;

   typedef enum logic [3:0] {
      BMID_ST_EXEC = 4'h1,
      BMID_ST_SECOND = 4'h2,
      BMID_ST_FLUSH = 4'h4,
      BMID_ST_FLUSH2 = 4'h8
   } bmid_state_t;
endpackage : bmid_pkg
`default_nettype wire

// ==== bmid_qdiv.sv ====
/*
 * Oscillator-phase divider: one enable pulse per instruction cycle.
 * Assumes a free-running core clock and asynchronous active-low reset.
 */
`default_nettype none
`include "bmid_consts.svh"
module bmid_qdiv #(
   parameter int PERIODS = `BMID_OSC_PER_CYCLE
) (
   input wire logic clk,
   input wire logic rst_n,
   output logic cycle_en,
   output logic [1:0] phase
);
   // the two-bit phase counter wraps only at four
   if (PERIODS != 4) begin : g_periods_check
      $error("bmid_qdiv: only four phases supported");
   end

   logic [1:0] phase_r;
   logic [1:0] phase_nxt;

   always_comb begin
      phase_nxt = phase_r + 2'h1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= 2'h0;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   assign phase = phase_r;
   // pulse on the last phase so decode outputs move once per cycle
   assign cycle_en = (phase_r == 2'h3);
endmodule // bmid_qdiv
`default_nettype wire

// ==== bmid_decode_properties.sv ====
/* Port assertions for the instruction decoder.
   Assumes it is bound onto bmid_decode and sees only its ports. */
`default_nettype none
module bmid_decode_checker
   import bmid_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic COND_TRUE,
   input wire logic FETCH_ADVANCE,
   input wire logic CYCLE_EN,
   input wire logic [3:0] GROUP,
   input wire logic [7:0] OPCODE,
   input wire logic DEST_FILE,
   input wire logic WR_WORKING_REG,
   input wire logic WR_FILE_REG,
   input wire logic ACCESS_SEL,
   input wire logic [2:0] BIT_NUM,
   input wire logic NOP_CYCLE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESET_N);
   // compare-and-skip taken, seen one edge after its cycle
   sequence s_skip;
      CYCLE_EN && COND_TRUE ##1 OPCODE[7:1] == 7'h31 && !NOP_CYCLE;
   endsequence
   // second word keeps the opcode; anchoring on both keeps the flush cycle out
   sequence s_goto;
      CYCLE_EN ##1 OPCODE == 8'hef && !NOP_CYCLE ##4 OPCODE == 8'hef && !NOP_CYCLE;
   endsequence
   property p_cyc;
      CYCLE_EN |=> (!CYCLE_EN) [*3] ##1 CYCLE_EN;
   endproperty
   property p_adv;
      FETCH_ADVANCE |-> CYCLE_EN;
   endproperty
   property p_wrw;
      WR_WORKING_REG |-> GROUP == BMID_GRP_BYTE && !DEST_FILE && !WR_FILE_REG;
   endproperty
   property p_wrf;
      WR_FILE_REG |-> GROUP == BMID_GRP_BYTE && DEST_FILE;
   endproperty
   property p_quiet;
      NOP_CYCLE || OPCODE[7:4] == 4'hf |-> !WR_WORKING_REG && !WR_FILE_REG;
   endproperty
   // decoded outputs may only move on the edge that ends an instruction cycle
   property p_stand;
      !$past(CYCLE_EN) |-> $stable(GROUP) && $stable(OPCODE) && $stable(NOP_CYCLE);
   endproperty
   property p_skip;
      s_skip |-> ##4 NOP_CYCLE;
   endproperty
   property p_goto;
      s_goto |-> ##4 NOP_CYCLE;
   endproperty
   property p_bit;
      GROUP == BMID_GRP_BIT && !NOP_CYCLE |-> BIT_NUM == OPCODE[3:1];
   endproperty
   property p_acc;
      (GROUP == BMID_GRP_BYTE || GROUP == BMID_GRP_BIT) && !NOP_CYCLE |-> ACCESS_SEL == OPCODE[0];
   endproperty
   a_cyc: assert property (p_cyc) else $error("cycle enable spacing wrong");
   a_adv: assert property (p_adv) else $error("fetch advance off cycle");
   a_wrw: assert property (p_wrw) else $error("working write bad");
   a_wrf: assert property (p_wrf) else $error("file write bad");
   a_quiet: assert property (p_quiet) else $error("write in nop cycle");
   a_stand: assert property (p_stand) else $error("output moved mid cycle");
   a_skip: assert property (p_skip) else $error("skip not flushed");
   a_goto: assert property (p_goto) else $error("branch not three cycles");
   a_bit: assert property (p_bit) else $error("bit number field wrong");
   a_acc: assert property (p_acc) else $error("access field wrong");
endmodule // bmid_decode_checker
bind bmid_decode bmid_decode_checker chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .COND_TRUE(COND_TRUE),
   .FETCH_ADVANCE(FETCH_ADVANCE), .CYCLE_EN(CYCLE_EN), .GROUP(GROUP), .OPCODE(OPCODE), .DEST_FILE(DEST_FILE),
   .WR_WORKING_REG(WR_WORKING_REG), .WR_FILE_REG(WR_FILE_REG), .ACCESS_SEL(ACCESS_SEL), .BIT_NUM(BIT_NUM),
   .NOP_CYCLE(NOP_CYCLE));
`default_nettype wire

// ==== bmid_fetch_model.sv ====
/* Program memory fetch model: one word per advance.
   Assumes the bench loads mem while reset is held. */
`default_nettype none
module bmid_fetch_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic advance,
   output logic [15:0] word,
   output logic valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:15];
   logic [3:0] pc_r;
   // unused slots read as lone second words
   initial for (int i = 0; i < 16; i++) mem[i] = 16'hf000;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pc_r <= 4'h0;
      else if (advance) pc_r <= pc_r + 4'h1;
   end
   assign word = mem[pc_r];
   assign valid = rst_n;
endmodule // bmid_fetch_model
`default_nettype wire

// ==== byte_mcu_instruction_decode_tb.sv ====
/* Self-checking bench for the instruction decoder.
   Assumes bmid_pkg, bmid_decode, the fetch model and the checker are compiled first. */
`default_nettype none
module byte_mcu_instruction_decode_tb;
   import bmid_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cond = 1'b0;
   logic ext = 1'b0;
   logic xt;
   logic [1:0] tmode;
   logic [15:0] word;
   logic valid, adv, cyc_en, dest, wrw, wrf, acc, callm, tw, nop, iv;
   logic [3:0] grp;
   logic [7:0] opc, fsel, lit;
   logic [2:0] bnum;
   logic [1:0] ptr;
   logic [19:0] paddr;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc_cnt = 0;
   bmid_fetch_model fm (.clk(clk), .rst_n(rst_n), .advance(adv), .word(word), .valid(valid));
   bmid_decode uut (.CORE_CLK(clk), .RESET_N(rst_n), .FETCH_WORD(word), .FETCH_VALID(valid), .COND_TRUE(cond),
      .EXT_ENABLE(ext), .FETCH_ADVANCE(adv), .CYCLE_EN(cyc_en), .GROUP(grp), .OPCODE(opc), .FILE_SEL(fsel),
      .DEST_FILE(dest), .WR_WORKING_REG(wrw), .WR_FILE_REG(wrf), .ACCESS_SEL(acc), .BIT_NUM(bnum),
      .LITERAL(lit), .PTR_SEL(ptr), .PROG_ADDR(paddr), .CALL_MODE(callm), .TABLE_MODE(tmode), .IS_EXTENDED(xt),
      .TWO_WORD(tw), .NOP_CYCLE(nop), .INSTR_VALID(iv));
   initial forever #2.5 clk = ~clk;
   task automatic results;
      if (error_cnt == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 3000) begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // eight program words, first word in the top bits
   task automatic boot(input logic [127:0] prog);
      @(posedge clk) rst_n <= 1'b0;
      @(negedge clk);
      for (int i = 0; i < 8; i++) fm.mem[i] = prog[127-16*i -: 16];
      chk(iv, 20'h0);
      @(posedge clk);
      @(posedge clk) rst_n <= 1'b1;
   endtask
   // returns settled just after the edge that takes the next word
   task automatic step(input logic c);
      @(posedge clk) cond <= c;
      @(negedge clk);
      for (int n = 0; n < 6 && cyc_en !== 1'b1; n++) @(negedge clk);
      if (cyc_en !== 1'b1) begin
         error_cnt++;
         $display("Error %0t: no instruction cycle", $time);
      end
      chk(adv, 20'h1);
      @(negedge clk);
   endtask
   task automatic t_byte;
      boot(128'h2455_27aa_f000_f000_f000_f000_f000_f000);
      step(1'h0);
      chk(grp, BMID_GRP_BYTE);
      chk(opc, 20'h24);
      chk(fsel, 20'h55);
      chk({wrw, wrf, acc}, 20'h4);
      step(1'h0);
      chk({fsel, dest, acc}, 20'h2ab);
      chk({wrw, wrf}, 20'h1);
   endtask
   task automatic t_bitlit;
      boot(128'h8b33_0e42_ee10_f034_2455_f000_f000_f000);
      step(1'h0);
      chk({grp, bnum, fsel, acc}, {4'h2, 3'h5, 8'h33, 1'h1});
      step(1'h0);
      chk({grp, lit}, {4'h4, 8'h42});
      step(1'h0);
      chk({grp, ptr, tw}, {4'h4, 2'h1, 1'h1});
      step(1'h0);
      chk({wrw, wrf}, 20'h0);
      step(1'h0);
      chk({nop, wrw}, 20'h1);
   endtask
   task automatic t_goto;
      boot(128'hef12_f345_2455_0013_f000_f000_f000_f000);
      step(1'h0);
      chk({grp, tw}, {4'h8, 1'h1});
      step(1'h0);
      chk(paddr, 20'h12345);
      step(1'h0);
      chk({nop, wrw}, 20'h2);
      step(1'h0);
      chk({grp, callm, nop}, {4'h8, 1'h1, 1'h0});
   endtask
   task automatic t_skip;
      boot(128'h6201_2455_6201_2455_6201_c001_f002_2600);
      step(1'h0);
      step(1'h0);
      chk({nop, wrw}, 20'h1);
      step(1'h1);
      step(1'h0);
      chk({nop, wrw}, 20'h2);
      step(1'h1);
      step(1'h0);
      chk(nop, 20'h1);
      step(1'h0);
      chk(nop, 20'h1);
      step(1'h0);
      chk({nop, wrf}, 20'h1);
   endtask
   // table mode, then the extended group with the enable on and off
   task automatic t_ext;
      @(posedge clk) ext <= 1'b1;
      boot(128'h0009_e842_e842_f000_f000_f000_f000_f000);
      step(1'h0);
      chk({grp, tmode, xt, iv}, {4'h8, 2'h1, 1'h0, 1'h1});
      step(1'h0);
      chk({grp, xt}, {4'h8, 1'h1});
      @(posedge clk) ext <= 1'b0;
      step(1'h0);
      chk(xt, 20'h0);
   endtask
   initial begin
      t_byte();
      t_bitlit();
      t_goto();
      t_skip();
      t_ext();
      results();
   end
endmodule // byte_mcu_instruction_decode_tb
`default_nettype wire
